// [rtl/mcis_core.v]
/*
 * Execution core for a subset of a 14-bit instruction set with its
 * watchdog, reached over an AHB-Lite slave port.
 * Assumes a single 25 MHz clock and one AHB-Lite master, whole-word
 * single transfers; writing the instruction register executes it.
 */
`timescale 1ns/1ps
`include "mcis_consts.vh"

module mcis_core #(
    parameter WDT_BASE_CYC = `MCIS_WDT_BASE_CYC
) (
    input wire clk_sys,
    input wire nrst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    output reg wdt_reset_req,
    output reg sleeping
);

    localparam ST_IDLE = 3'b001;
    localparam ST_EXEC = 3'b010;
    localparam ST_FLUSH = 3'b100;

    reg [2:0] state_r;
    reg [7:0] acc_r;
    reg [`MCIS_ST_WIDTH-1:0] status_r;
    reg [12:0] pc_r;
    reg [4:0] pc_upper_latch_r;
    reg [`MCIS_OPT_WIDTH-1:0] option_r;
    reg [13:0] instr_r;
    reg [6:0] faddr_r;
    reg [7:0] file_mem [0:`MCIS_FILE_DEPTH-1];
    reg [12:0] stack_mem [0:`MCIS_STACK_DEPTH-1];
    reg [2:0] sp_r;
    reg [31:0] wdt_cnt_r;
    reg [6:0] wdt_ps_r;
    reg ph_wr_r;
    reg ph_rd_r;
    reg [11:0] ph_addr_r;
    reg skip_r;

    wire [7:0] fval = file_mem[instr_r[6:0]];
    wire dbit = instr_r[7];
    wire ps_wdt = option_r[`MCIS_OPT_PSA];
    wire [7:0] ps_lim = ps_wdt ? (8'h01 << option_r[`MCIS_OPT_PS_HI:0]) : 8'h01;
    wire wdt_tick = (wdt_cnt_r == WDT_BASE_CYC - 1);
    wire wdt_expire = wdt_tick && ({1'b0, wdt_ps_r} == ps_lim - 8'h01);
    wire wdt_clr_exec = (state_r == ST_EXEC) && !skip_r
        && (instr_r == `MCIS_OP_DOG_CLR || instr_r == `MCIS_OP_SLEEP);
    wire addr_ok = hsel && htrans[1] && hready;

    function zero_of;
        input [7:0] v;
        begin
            zero_of = (v == 8'h00);
        end
    endfunction

    // Bus address and data phases; writes land in data phase
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ph_wr_r <= 1'b0;
            ph_rd_r <= 1'b0;
            ph_addr_r <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            ph_wr_r <= addr_ok && hwrite;
            ph_rd_r <= addr_ok && !hwrite;
            if (addr_ok) begin
                ph_addr_r <= haddr[11:0];
            end
            // Hold off the next transfer while an instruction is in flight
            hreadyout <= !(ph_wr_r && ph_addr_r == `MCIS_OFS_INSTR) && state_r == ST_IDLE;
        end
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            case (haddr[11:0])
                `MCIS_OFS_INSTR: hrdata <= {18'h00000, instr_r};
                `MCIS_OFS_ACC: hrdata <= {24'h000000, acc_r};
                `MCIS_OFS_STATUS: hrdata <= {25'h0000000, status_r};
                `MCIS_OFS_PC: hrdata <= {19'h00000, pc_r};
                `MCIS_OFS_OPTION: hrdata <= {28'h0000000, option_r};
                `MCIS_OFS_FADDR: hrdata <= {25'h0000000, faddr_r};
                `MCIS_OFS_FDATA: hrdata <= {24'h000000, file_mem[faddr_r]};
                `MCIS_OFS_PC_UPPER: hrdata <= {27'h0000000, pc_upper_latch_r};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Watchdog counter and prescaler
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wdt_cnt_r <= 32'h0000_0000;
            wdt_ps_r <= 7'h00;
            wdt_reset_req <= 1'b0;
        end else begin
            wdt_reset_req <= 1'b0;
            if (wdt_clr_exec) begin
                wdt_cnt_r <= 32'h0000_0000;
                wdt_ps_r <= 7'h00;
            end else if (wdt_tick) begin
                wdt_cnt_r <= 32'h0000_0000;
                if (wdt_expire) begin
                    wdt_ps_r <= 7'h00;
                    wdt_reset_req <= !status_r[`MCIS_ST_SLEEP];
                end else begin
                    wdt_ps_r <= wdt_ps_r + 7'h01;
                end
            end else begin
                wdt_cnt_r <= wdt_cnt_r + 32'h0000_0001;
            end
        end
    end

    // Execution and register writes
    always @(posedge clk_sys or negedge nrst) begin : exec
        reg [8:0] sum;
        reg [4:0] nsum;
        reg [7:0] res;
        reg wres;
        reg zupd;
        sum = 9'h000;
        nsum = 5'h00;
        res = 8'h00;
        wres = 1'b0;
        zupd = 1'b0;
        if (!nrst) begin
            state_r <= ST_IDLE;
            acc_r <= 8'h00;
            status_r <= `MCIS_ST_RESET;
            pc_r <= 13'h0000;
            pc_upper_latch_r <= 5'h00;
            option_r <= `MCIS_OPT_RESET;
            instr_r <= 14'h0000;
            faddr_r <= 7'h00;
            sp_r <= 3'h0;
            skip_r <= 1'b0;
            sleeping <= 1'b0;
        end else begin
            if (wdt_expire) begin
                status_r[`MCIS_ST_TO] <= 1'b0;
                status_r[`MCIS_ST_SLEEP] <= 1'b0;
                status_r[`MCIS_ST_WRST] <= !status_r[`MCIS_ST_SLEEP];
                sleeping <= 1'b0;
            end
            case (state_r)
                ST_IDLE: begin
                    if (ph_wr_r) begin
                        case (ph_addr_r)
                            `MCIS_OFS_INSTR: begin
                                instr_r <= hwdata[13:0];
                                state_r <= ST_EXEC;
                            end
                            `MCIS_OFS_ACC: acc_r <= hwdata[7:0];
                            `MCIS_OFS_STATUS: status_r[2:0] <= hwdata[2:0];
                            `MCIS_OFS_PC: pc_r <= hwdata[12:0];
                            `MCIS_OFS_OPTION: option_r <= hwdata[`MCIS_OPT_WIDTH-1:0];
                            `MCIS_OFS_FADDR: faddr_r <= hwdata[6:0];
                            `MCIS_OFS_FDATA: file_mem[faddr_r] <= hwdata[7:0];
                            `MCIS_OFS_PC_UPPER: pc_upper_latch_r <= hwdata[4:0];
                            default: begin
                            end
                        endcase
                    end
                end
                ST_EXEC: begin
                    state_r <= ST_IDLE;
                    pc_r <= pc_r + 13'h0001;
                    if (skip_r) begin
                        skip_r <= 1'b0;
                    end else if (instr_r[13:12] == 2'b00 && instr_r[11:8] != 4'h0) begin
                        wres = 1'b1;
                        zupd = 1'b1;
                        case (instr_r[13:8])
                            `MCIS_OP_ADD_FILE: begin
                                sum = {1'b0, acc_r} + {1'b0, fval};
                                nsum = {1'b0, acc_r[3:0]} + {1'b0, fval[3:0]};
                                res = sum[7:0];
                                status_r[`MCIS_ST_C] <= sum[8];
                                status_r[`MCIS_ST_NC] <= nsum[4];
                            end
                            `MCIS_OP_AND_FILE: res = acc_r & fval;
                            `MCIS_OP_CPL_FILE: res = ~fval;
                            `MCIS_OP_DEC_FILE: res = fval - 8'h01;
                            `MCIS_OP_DEC_SKIP: begin
                                res = fval - 8'h01;
                                zupd = 1'b0;
                                if (res == 8'h00) begin
                                    skip_r <= 1'b1;
                                    state_r <= ST_EXEC;
                                end
                            end
                            `MCIS_OP_ROT_RIGHT: begin
                                res = {status_r[`MCIS_ST_C], fval[7:1]};
                                status_r[`MCIS_ST_C] <= fval[0];
                                zupd = 1'b0;
                            end
                            default: begin
                                if (instr_r[13:7] == `MCIS_OP_CLR_FILE) begin
                                    res = 8'h00;
                                end else begin
                                    wres = 1'b0;
                                    zupd = 1'b0;
                                end
                            end
                        endcase
                        if (wres) begin
                            if (dbit) begin
                                file_mem[instr_r[6:0]] <= res;
                            end else begin
                                acc_r <= res;
                            end
                        end
                        if (zupd) begin
                            status_r[`MCIS_ST_Z] <= zero_of(res);
                        end
                    end else if (instr_r[13:8] == `MCIS_OP_AND_LIT) begin
                        res = acc_r & instr_r[7:0];
                        acc_r <= res;
                        status_r[`MCIS_ST_Z] <= zero_of(res);
                    end else if (instr_r[13:11] == `MCIS_OP_CALL) begin
                        stack_mem[sp_r] <= pc_r + 13'h0001;
                        sp_r <= sp_r + 3'h1;
                        pc_r <= {pc_upper_latch_r[4:3], instr_r[10:0]};
                        state_r <= ST_FLUSH;
                    end else if (instr_r[13:10] == `MCIS_OP_BIT_SKIP) begin
                        if (fval[instr_r[9:7]]) begin
                            skip_r <= 1'b1;
                            state_r <= ST_EXEC;
                        end
                    end else if (instr_r == `MCIS_OP_RETURN) begin
                        pc_r <= stack_mem[sp_r - 3'h1];
                        sp_r <= sp_r - 3'h1;
                        state_r <= ST_FLUSH;
                    end else if (instr_r == `MCIS_OP_DOG_CLR) begin
                        if (!wdt_expire) begin
                            status_r[`MCIS_ST_TO] <= 1'b1;
                        end
                        status_r[`MCIS_ST_PWDN] <= 1'b1;
                    end else if (instr_r == `MCIS_OP_SLEEP) begin
                        if (!wdt_expire) begin
                            status_r[`MCIS_ST_TO] <= 1'b1;
                            status_r[`MCIS_ST_SLEEP] <= 1'b1;
                            sleeping <= 1'b1;
                        end
                        status_r[`MCIS_ST_PWDN] <= 1'b0;
                    end
                end
                ST_FLUSH: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

endmodule // mcis_core

// [rtl/mcis_consts.vh]
/*
 * Constants for the instruction subset core: opcodes, register offsets,
 * status bits and watchdog timing. Included by the core; no logic here.
 */
`ifndef MCIS_CONSTS_VH
`define MCIS_CONSTS_VH

// Register byte offsets on the bus
`define MCIS_OFS_INSTR 12'h000
`define MCIS_OFS_ACC 12'h004
`define MCIS_OFS_STATUS 12'h008
`define MCIS_OFS_PC 12'h00c
`define MCIS_OFS_OPTION 12'h010
`define MCIS_OFS_FADDR 12'h014
`define MCIS_OFS_FDATA 12'h018
`define MCIS_OFS_PC_UPPER 12'h01c
`define MCIS_OFS_CTRL 12'h020

// Status register bit positions
`define MCIS_ST_C 0
`define MCIS_ST_NC 1
`define MCIS_ST_Z 2
`define MCIS_ST_PWDN 3
`define MCIS_ST_TO 4
`define MCIS_ST_SLEEP 5
`define MCIS_ST_WRST 6
`define MCIS_ST_WIDTH 7
// Timeout and powerdown flags both set out of reset
`define MCIS_ST_RESET 7'h18

// Option register fields
`define MCIS_OPT_PS_HI 2
`define MCIS_OPT_PSA 3
`define MCIS_OPT_WIDTH 4
`define MCIS_OPT_RESET 4'h8

// Opcode patterns
`define MCIS_OP_ADD_FILE 6'h07
`define MCIS_OP_AND_FILE 6'h05
`define MCIS_OP_CLR_FILE 7'h03
`define MCIS_OP_CPL_FILE 6'h09
`define MCIS_OP_DEC_FILE 6'h03
`define MCIS_OP_DEC_SKIP 6'h0b
`define MCIS_OP_ROT_RIGHT 6'h0c
`define MCIS_OP_AND_LIT 6'h39
`define MCIS_OP_CALL 3'h4
`define MCIS_OP_BIT_SKIP 4'h7
`define MCIS_OP_DOG_CLR 14'h0064
`define MCIS_OP_SLEEP 14'h0063
`define MCIS_OP_RETURN 14'h0008

// Watchdog timing, stack and file depths
`define MCIS_WDT_MS 18
`define MCIS_CLK_KHZ 25000
`define MCIS_WDT_BASE_CYC (`MCIS_WDT_MS * `MCIS_CLK_KHZ)
`define MCIS_PS_MAX 128
`define MCIS_STACK_DEPTH 8
`define MCIS_FILE_DEPTH 128

`endif

// [tb/mcis_core_props.sv]
/* Checker for the core's bus and watchdog ports.
   Assumes one clock and the bind in the bench top file. */
`timescale 1ns/1ps
module mcis_core_props #(parameter WDT_BASE_CYC = 20) (
    input wire clk_sys,
    input wire nrst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire wdt_reset_req,
    input wire sleeping
);
    reg [31:0] gap_r;
    // Cycles since reset or the last reset request; a clear only makes the gap longer
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            gap_r <= 32'h0;
        else if (wdt_reset_req)
            gap_r <= 32'h0;
        else
            gap_r <= gap_r + 32'h1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Registered ready adds one cycle to the one or two execution cycles
    exec_stall_a: assert property ($fell(hreadyout) |-> ##[2:3] hreadyout)
        else $error("execution stall longer than three cycles");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    read_fast_a: assert property (hsel && htrans[1] && !hwrite && hready |=> hreadyout)
        else $error("read stalled");
    idle_ready_a: assert property (!hsel [*4] |=> hreadyout)
        else $error("stall without a transfer");
    wdt_pulse_a: assert property (wdt_reset_req |=> !wdt_reset_req)
        else $error("expiry pulse longer than one cycle");
    run_reset_a: assert property (wdt_reset_req |-> !$past(sleeping))
        else $error("reset request while sleeping");
    wake_quiet_a: assert property ($fell(sleeping) |-> !wdt_reset_req)
        else $error("wake came with a reset request");
    wdt_period_a: assert property (wdt_reset_req |-> gap_r >= WDT_BASE_CYC - 1)
        else $error("watchdog expired early");
    cover property (!hreadyout [*2]);
    cover property (wdt_reset_req);
    cover property ($fell(sleeping));
endmodule // mcis_core_props

// [tb/mcis_prog_mem.sv]
/* Program memory model holding the test program's 14-bit words.
   Assumes the bench presents a word address and copies the word out. */
`timescale 1ns/1ps
module mcis_prog_mem (
    input wire [3:0] addr,
    output wire [13:0] word
);
    reg [13:0] mem [0:15];
    initial begin
        mem[0] = 14'h395f;
        mem[1] = 14'h3900;
        mem[2] = 14'h0785;
        mem[3] = 14'h0185;
        mem[4] = 14'h0905;
        mem[5] = 14'h0385;
        mem[6] = 14'h0b85;
        mem[7] = 14'h0c05;
        mem[8] = 14'h2123;
        mem[9] = 14'h0008;
        mem[10] = 14'h0064;
        mem[11] = 14'h0063;
        mem[12] = 14'h077f;
        mem[13] = 14'h05ff;
        mem[14] = 14'h1c05;
        mem[15] = 14'h0000;
    end
    assign word = mem[addr];
endmodule // mcis_prog_mem

// [tb/midrange_core_instruction_subset_test.sv]
/* Self-checking bench: executes program words through the bus.
   Assumes the core's single-slave AHB-Lite port and a short watchdog. */
`timescale 1ns/1ps
`include "mcis_consts.vh"
module midrange_core_instruction_subset_test;
    reg clk_sys = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    reg [31:0] haddr = 32'h0, hwdata = 32'h0, rdat, pc0;
    reg [1:0] htrans = 2'h0;
    reg [3:0] pm_addr = 4'h0;
    wire hreadyout, hresp, wdt_reset_req, sleeping;
    wire [31:0] hrdata;
    wire [13:0] pm_word;
    integer fails = 0, checks_done = 0, n;
    initial forever #20 clk_sys = ~clk_sys;
    mcis_prog_mem u_mem (.addr(pm_addr), .word(pm_word));
    mcis_core #(.WDT_BASE_CYC(20)) DUT (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wdt_reset_req(wdt_reset_req), .sleeping(sleeping));
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", checks_done, fails);
            if (fails == 0 && checks_done > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // Bounded wait for an edge that samples ready high
    task hold_ready;
        begin
            n = 0;
            @(posedge clk_sys);
            while (hreadyout !== 1'b1 && n < 50) begin
                n = n + 1;
                @(posedge clk_sys);
            end
            if (n == 50) begin
                fails = fails + 1;
                complete_run;
            end
        end
    endtask
    task bus(input [11:0] a, input w, input [31:0] d);
        begin
            hsel <= 1'b1;
            haddr <= {20'h0, a};
            htrans <= 2'h2;
            hwrite <= w;
            hold_ready;
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            hold_ready;
            rdat = hrdata;
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task rd_chk(input [11:0] a, input [31:0] mask, input [31:0] exp);
        begin
            bus(a, 1'b0, 32'h0);
            chk(rdat & mask, exp);
        end
    endtask
    task exec(input [3:0] i);
        begin
            pm_addr = i;
            #1;
            wr(`MCIS_OFS_INSTR, {18'h0, pm_word});
        end
    endtask
    task setf(input [6:0] f, input [7:0] v);
        begin
            wr(`MCIS_OFS_FADDR, {25'h0, f});
            wr(`MCIS_OFS_FDATA, {24'h0, v});
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails = fails + 1;
        complete_run;
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rd_chk(`MCIS_OFS_STATUS, 32'hff, 32'h18);
        rd_chk(`MCIS_OFS_OPTION, 32'hff, 32'h8);
        // Longest ratio keeps the watchdog quiet through the ALU tests
        wr(`MCIS_OFS_OPTION, 32'hf);
        exec(4'd10);
        wr(`MCIS_OFS_ACC, 32'ha3);
        exec(4'd0);
        rd_chk(`MCIS_OFS_ACC, 32'hff, 32'h03);
        rd_chk(`MCIS_OFS_STATUS, 32'h4, 32'h0);
        exec(4'd1);
        rd_chk(`MCIS_OFS_STATUS, 32'h4, 32'h4);
        wr(`MCIS_OFS_STATUS, 32'h0);
        wr(`MCIS_OFS_ACC, 32'h17);
        setf(7'd5, 8'he9);
        exec(4'd2);
        rd_chk(`MCIS_OFS_FDATA, 32'hff, 32'h0);
        rd_chk(`MCIS_OFS_STATUS, 32'h7, 32'h7);
        setf(7'd127, 8'h02);
        exec(4'd12);
        rd_chk(`MCIS_OFS_ACC, 32'hff, 32'h19);
        rd_chk(`MCIS_OFS_STATUS, 32'h7, 32'h0);
        rd_chk(`MCIS_OFS_FDATA, 32'hff, 32'h02);
        exec(4'd13);
        rd_chk(`MCIS_OFS_FDATA, 32'hff, 32'h0);
        rd_chk(`MCIS_OFS_STATUS, 32'h7, 32'h4);
        $display("add and and tests done");
        setf(7'd5, 8'h5a);
        wr(`MCIS_OFS_STATUS, 32'h0);
        exec(4'd3);
        rd_chk(`MCIS_OFS_FDATA, 32'hff, 32'h0);
        rd_chk(`MCIS_OFS_STATUS, 32'h4, 32'h4);
        setf(7'd5, 8'h13);
        exec(4'd4);
        rd_chk(`MCIS_OFS_ACC, 32'hff, 32'hec);
        rd_chk(`MCIS_OFS_STATUS, 32'h4, 32'h0);
        setf(7'd5, 8'h01);
        exec(4'd5);
        rd_chk(`MCIS_OFS_FDATA, 32'hff, 32'h0);
        rd_chk(`MCIS_OFS_STATUS, 32'h4, 32'h4);
        setf(7'd5, 8'h01);
        wr(`MCIS_OFS_STATUS, 32'h0);
        exec(4'd6);
        rd_chk(`MCIS_OFS_FDATA, 32'hff, 32'h0);
        rd_chk(`MCIS_OFS_STATUS, 32'h7, 32'h0);
        wr(`MCIS_OFS_STATUS, 32'h1);
        setf(7'd5, 8'he6);
        exec(4'd7);
        rd_chk(`MCIS_OFS_ACC, 32'hff, 32'hf3);
        rd_chk(`MCIS_OFS_STATUS, 32'h1, 32'h0);
        $display("file tests done");
        wr(`MCIS_OFS_PC_UPPER, 32'h18);
        bus(`MCIS_OFS_PC, 1'b0, 32'h0);
        pc0 = rdat;
        exec(4'd8);
        rd_chk(`MCIS_OFS_PC, 32'h1fff, 32'h1923);
        exec(4'd9);
        rd_chk(`MCIS_OFS_PC, 32'h1fff, (pc0 + 32'h1) & 32'h1fff);
        setf(7'd5, 8'h01);
        bus(`MCIS_OFS_PC, 1'b0, 32'h0);
        pc0 = rdat;
        exec(4'd14);
        rd_chk(`MCIS_OFS_PC, 32'h1fff, (pc0 + 32'h2) & 32'h1fff);
        $display("call and return tests done");
        wr(`MCIS_OFS_OPTION, 32'h8);
        exec(4'd10);
        rd_chk(`MCIS_OFS_STATUS, 32'h18, 32'h18);
        n = 0;
        while (wdt_reset_req !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            n = n + 1;
        end
        chk({31'h0, wdt_reset_req}, 32'h1);
        rd_chk(`MCIS_OFS_STATUS, 32'h10, 32'h0);
        exec(4'd11);
        // Sleep lands one edge after the data phase ends
        repeat (2) @(posedge clk_sys);
        chk({31'h0, sleeping}, 32'h1);
        rd_chk(`MCIS_OFS_STATUS, 32'h18, 32'h10);
        n = 0;
        while (sleeping !== 1'b0 && n < 200) begin
            @(posedge clk_sys);
            n = n + 1;
        end
        chk({31'h0, sleeping}, 32'h0);
        rd_chk(`MCIS_OFS_STATUS, 32'h10, 32'h0);
        $display("watchdog tests done");
        complete_run;
    end
endmodule // midrange_core_instruction_subset_test
bind mcis_core mcis_core_props #(.WDT_BASE_CYC(20)) u_props (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wdt_reset_req(wdt_reset_req), .sleeping(sleeping));
